/* File: logic/alu_function_carry_status.sv */
// ALU function control, carry flag and processor status word slice
`timescale 1ns/1ps
module alu_function_carry_status (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  bSourceClassField,
  input  wire logic [3:0]  bSourceSelectField,
  input  wire logic [3:0]  functionSelectField,
  input  wire logic        modeSelectField,
  input  wire logic [1:0]  carryInSelectField,
  input  wire logic [1:0]  statusUpdateField,
  input  wire logic [2:0]  testSelectField,
  input  wire logic [3:0]  groupControlField,
  input  wire logic [15:0] operandA,
  input  wire logic [15:0] operandB,
  input  wire logic        supervisorFlag,
  input  wire logic        overflowFlag,
  input  wire logic [7:0]  shiftCount,
  input  wire logic [3:0]  keyBits,
  output logic      [15:0] bBusValue,
  output logic      [15:0] aluResult,
  output logic             aluCarryOut,
  output logic             effectiveLogicMode,
  output logic             effectiveCarryIn,
  output logic             gprWriteBlock,
  output logic             storedCarryFlag,
  output logic             resultZeroFlag,
  output logic             resultAllOnesFlag,
  output logic             resultSignFlag,
  output logic [15:0]      processorStatusWord
);
  import alu_function_pkg::*;

  typedef struct packed {
    logic [15:0] bBus;
    logic [15:0] result;
    logic        carryOut;
    logic        logicMode;
    logic        carryIn;
    logic        writeBlock;
    logic        storedCarry;
    logic        zeroFlag;
    logic        allOnesFlag;
    logic        signFlag;
    logic [15:0] statusWord;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // Literal or mask replaces the mode field with function bit 1 and the carry field with zero
  function automatic logic isLiteralSource(input logic [1:0] classField);
    isLiteralSource = (classField == B_CLASS_MASK) || (classField == B_CLASS_LITERAL);
  endfunction : isLiteralSource

  function automatic logic selectCarry(input logic [1:0] sel, input logic stored);
    case (carry_sel_type'(sel))
      CARRY_ZERO:       selectCarry = 1'b0;
      CARRY_STORED:     selectCarry = stored;
      CARRY_STORED_INV: selectCarry = ~stored;
      CARRY_ONE:        selectCarry = 1'b1;
      default:          selectCarry = 1'b0;
    endcase
  endfunction : selectCarry

  logic        literalSource;
  logic        statusOnB;
  logic        modeNow;
  logic        carryNow;
  logic [15:0] bNow;
  logic [15:0] unitResult;
  logic        unitCarry;
  logic        carryUpdate;
  logic [15:0] statusNow;

  assign literalSource = isLiteralSource(bSourceClassField);
  assign statusOnB     = (bSourceClassField == B_CLASS_SPECIAL) &&
                         (bSourceSelectField == B_SELECT_STATUS);

  // The stored status word goes on B so the operation sees flags of the
  // previous result, never its own combinational output
  assign bNow = statusOnB ? state_r.statusWord : operandB;

  // Mode comes from the field, or from function bit 1 under a literal
  assign modeNow = literalSource ? functionSelectField[FUNC_MODE_BIT]
                                 : modeSelectField;

  // A literal forces carry in to zero; the logical path discards it anyway
  assign carryNow = literalSource ? 1'b0
                                  : selectCarry(carryInSelectField, state_r.storedCarry);

  // Every field combination runs; named operations are just some of them
  alu_function_unit u_function (
    .functionSelect (functionSelectField),
    .logicMode      (modeNow),
    .carryIn        (carryNow),
    .operandA       (operandA),
    .operandB       (bNow),
    .result         (unitResult),
    .carryOut       (unitCarry)
  );

  assign carryUpdate = ((statusUpdateField == STATUS_UPDATE_ZERO) ||
                        (statusUpdateField == STATUS_UPDATE_TWO)) &&
                       (testSelectField == TEST_SELECT_NONE) &&
                       groupControlField[GROUP_CARRY_BIT];

  always_comb begin
    state_nxt             = state_r;
    state_nxt.bBus        = bNow;
    state_nxt.result      = unitResult;
    state_nxt.carryOut    = unitCarry;
    state_nxt.logicMode   = modeNow;
    state_nxt.carryIn     = carryNow;
    state_nxt.writeBlock  = literalSource;
    state_nxt.zeroFlag    = (unitResult == WORD_ZERO);
    state_nxt.allOnesFlag = (unitResult == WORD_ONES);
    state_nxt.signFlag    = unitResult[DATA_W-1];
    if (carryUpdate) begin
      state_nxt.storedCarry = unitCarry;
    end
    state_nxt.statusWord  = statusNow;
  end

  // Status word is built from the flags being written this cycle, so it
  // matches the other flag outputs on every edge
  status_word_builder u_status (
    .supervisorFlag    (supervisorFlag),
    .resultZeroFlag    ((unitResult == WORD_ZERO)),
    .shiftCount        (shiftCount),
    .overflowFlag      (overflowFlag),
    .resultAllOnesFlag ((unitResult == WORD_ONES)),
    .resultSignFlag    (unitResult[DATA_W-1]),
    .storedCarryFlag   ((carryUpdate ? unitCarry : state_r.storedCarry)),
    .keyBits           (keyBits),
    .statusWord        (statusNow)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r.bBus        <= WORD_ZERO;
      state_r.result      <= WORD_ZERO;
      state_r.carryOut    <= FLAG_RESET;
      state_r.logicMode   <= FLAG_RESET;
      state_r.carryIn     <= FLAG_RESET;
      state_r.writeBlock  <= FLAG_RESET;
      state_r.storedCarry <= FLAG_RESET;
      state_r.zeroFlag    <= FLAG_RESET;
      state_r.allOnesFlag <= FLAG_RESET;
      state_r.signFlag    <= FLAG_RESET;
      state_r.statusWord  <= STATUS_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bBusValue           = state_r.bBus;
  assign aluResult           = state_r.result;
  assign aluCarryOut         = state_r.carryOut;
  assign effectiveLogicMode  = state_r.logicMode;
  assign effectiveCarryIn    = state_r.carryIn;
  assign gprWriteBlock       = state_r.writeBlock;
  assign storedCarryFlag     = state_r.storedCarry;
  assign resultZeroFlag      = state_r.zeroFlag;
  assign resultAllOnesFlag   = state_r.allOnesFlag;
  assign resultSignFlag      = state_r.signFlag;
  assign processorStatusWord = state_r.statusWord;

endmodule : alu_function_carry_status

/* File: logic/alu_function_pkg.sv */
// Shared constants and types for the ALU function, carry and status slice
package alu_function_pkg;

  localparam int unsigned DATA_W = 16;

  // B-source class field codes
  localparam logic [1:0] B_CLASS_REGISTER = 2'h0;
  localparam logic [1:0] B_CLASS_SPECIAL  = 2'h1;
  localparam logic [1:0] B_CLASS_MASK     = 2'h2;
  localparam logic [1:0] B_CLASS_LITERAL  = 2'h3;

  // B-source select code for the status word within the special class
  localparam logic [3:0] B_SELECT_STATUS  = 4'h3;

  // Carry-in select field codes
  typedef enum logic [1:0] {
    CARRY_ZERO       = 2'b00,
    CARRY_STORED     = 2'b01,
    CARRY_STORED_INV = 2'b10,
    CARRY_ONE        = 2'b11
  } carry_sel_type;

  // Status-update, test and group conditions for loading the stored carry
  localparam logic [1:0] STATUS_UPDATE_ZERO = 2'h0;
  localparam logic [1:0] STATUS_UPDATE_TWO  = 2'h2;
  localparam logic [2:0] TEST_SELECT_NONE   = 3'h0;
  localparam int unsigned GROUP_CARRY_BIT   = 1;

  // Function field bit that gives the mode when B is a literal or mask
  localparam int unsigned FUNC_MODE_BIT = 1;

  // Status word bit positions
  localparam int unsigned SW_ONE_POS        = 0;
  localparam int unsigned SW_SUPERVISOR_POS = 1;
  localparam int unsigned SW_ZERO_POS       = 2;
  localparam int unsigned SW_SHIFT_LO_POS   = 3;
  localparam int unsigned SW_SHIFT_BITS     = 5;
  localparam int unsigned SW_OVERFLOW_POS   = 8;
  localparam int unsigned SW_ALL_ONES_POS   = 9;
  localparam int unsigned SW_SIGN_POS       = 10;
  localparam int unsigned SW_CARRY_POS      = 11;
  localparam int unsigned SW_KEY_LO_POS     = 12;
  localparam int unsigned SW_KEY_BITS       = 4;

  // Word constants and values after reset
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [15:0] WORD_ONES     = 16'hFFFF;
  localparam logic [15:0] STATUS_RESET  = 16'h0001;
  localparam logic        FLAG_RESET    = 1'b0;

endpackage : alu_function_pkg

/* File: logic/alu_function_unit.sv */
// Sixteen arithmetic and sixteen logical ALU functions with carry out
`timescale 1ns/1ps
module alu_function_unit (
  input  wire logic [3:0]  functionSelect,
  input  wire logic        logicMode,
  input  wire logic        carryIn,
  input  wire logic [15:0] operandA,
  input  wire logic [15:0] operandB,
  output logic      [15:0] result,
  output logic             carryOut
);
  import alu_function_pkg::*;

  logic [15:0] termP;
  logic [15:0] termQ;
  logic [16:0] sum;
  logic [15:0] logicResult;

  // Arithmetic: result is termP plus termQ plus carry
  always_comb begin
    termP = operandA;
    termQ = WORD_ZERO;
    case (functionSelect)
      4'h0: begin termP = operandA;              termQ = WORD_ZERO;             end
      4'h1: begin termP = operandA | operandB;   termQ = WORD_ZERO;             end
      4'h2: begin termP = operandA | ~operandB;  termQ = WORD_ZERO;             end
      4'h3: begin termP = WORD_ZERO;             termQ = WORD_ONES;             end
      4'h4: begin termP = operandA;              termQ = operandA & ~operandB;  end
      4'h5: begin termP = operandA | operandB;   termQ = operandA & ~operandB;  end
      4'h6: begin termP = operandA;              termQ = ~operandB;             end
      4'h7: begin termP = operandA & ~operandB;  termQ = WORD_ONES;             end
      4'h8: begin termP = operandA;              termQ = operandA & operandB;   end
      4'h9: begin termP = operandA;              termQ = operandB;              end
      4'hA: begin termP = operandA | ~operandB;  termQ = operandA & operandB;   end
      4'hB: begin termP = operandA & operandB;   termQ = WORD_ONES;             end
      4'hC: begin termP = operandA;              termQ = operandA;              end
      4'hD: begin termP = operandA | operandB;   termQ = operandA;              end
      4'hE: begin termP = operandA | ~operandB;  termQ = operandA;              end
      4'hF: begin termP = operandA;              termQ = WORD_ONES;             end
      default: begin termP = operandA;           termQ = WORD_ZERO;             end
    endcase
  end

  // One unsigned 17-bit sum gives every documented carry condition; the
  // undefined cases simply report the same carry
  assign sum = {1'b0, termP} + {1'b0, termQ} + {16'h0000, carryIn};

  // Logical functions ignore carry
  always_comb begin
    case (functionSelect)
      4'h0:    logicResult = ~operandA;
      4'h1:    logicResult = ~(operandA | operandB);
      4'h2:    logicResult = ~operandA & operandB;
      4'h3:    logicResult = WORD_ZERO;
      4'h4:    logicResult = ~(operandA & operandB);
      4'h5:    logicResult = ~operandB;
      4'h6:    logicResult = operandA ^ operandB;
      4'h7:    logicResult = operandA & ~operandB;
      4'h8:    logicResult = ~operandA | operandB;
      4'h9:    logicResult = ~(operandA ^ operandB);
      4'hA:    logicResult = operandB;
      4'hB:    logicResult = operandA & operandB;
      4'hC:    logicResult = WORD_ONES;
      4'hD:    logicResult = operandA | ~operandB;
      4'hE:    logicResult = operandA | operandB;
      4'hF:    logicResult = operandA;
      default: logicResult = operandA;
    endcase
  end

  // Mode picks the path; logical operations report no carry
  assign result   = logicMode ? logicResult : sum[15:0];
  assign carryOut = logicMode ? 1'b0 : sum[16];

endmodule : alu_function_unit

/* File: logic/status_word_builder.sv */
// Assembles the 16-bit processor status word from flags and counters
`timescale 1ns/1ps
module status_word_builder (
  input  wire logic        supervisorFlag,
  input  wire logic        resultZeroFlag,
  input  wire logic [7:0]  shiftCount,
  input  wire logic        overflowFlag,
  input  wire logic        resultAllOnesFlag,
  input  wire logic        resultSignFlag,
  input  wire logic        storedCarryFlag,
  input  wire logic [3:0]  keyBits,
  output logic      [15:0] statusWord
);
  import alu_function_pkg::*;

  always_comb begin
    statusWord                                             = WORD_ZERO;
    statusWord[SW_ONE_POS]                                 = 1'b1;
    statusWord[SW_SUPERVISOR_POS]                          = supervisorFlag;
    statusWord[SW_ZERO_POS]                                = resultZeroFlag;
    statusWord[SW_SHIFT_LO_POS +: SW_SHIFT_BITS]           = shiftCount[SW_SHIFT_BITS-1:0];
    statusWord[SW_OVERFLOW_POS]                            = overflowFlag;
    statusWord[SW_ALL_ONES_POS]                            = resultAllOnesFlag;
    statusWord[SW_SIGN_POS]                                = resultSignFlag;
    statusWord[SW_CARRY_POS]                               = storedCarryFlag;
    statusWord[SW_KEY_LO_POS +: SW_KEY_BITS]               = keyBits;
  end

endmodule : status_word_builder

/* File: tb/operand_b_mux.sv */
// Operand-B multiplexer model: register, literal and mask paths
`timescale 1ns/1ps
module operand_b_mux (
  input  wire logic [1:0]  bSourceClassField,
  input  wire logic [15:0] regValue,
  input  wire logic [15:0] literalBits,
  output logic      [15:0] operandB
);
  // A mask bit of one zeroes the register bit; the literal is sent complemented
  always_comb begin
    case (bSourceClassField)
      2'h2: operandB = regValue & ~literalBits;
      2'h3: operandB = ~literalBits;
      default: operandB = regValue;
    endcase
  end
  // Function 0011 with literal or mask has bit 1 set, so minus-one never arrives in arithmetic mode
endmodule : operand_b_mux

/* File: tb/alu_function_carry_status_assertions.sv */
// Port-level assertions for the ALU function, carry and status slice
`timescale 1ns/1ps
module alu_function_carry_status_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [1:0]  bSourceClassField,
  input wire logic [3:0]  bSourceSelectField,
  input wire logic [3:0]  functionSelectField,
  input wire logic        modeSelectField,
  input wire logic [1:0]  carryInSelectField,
  input wire logic [1:0]  statusUpdateField,
  input wire logic [2:0]  testSelectField,
  input wire logic [3:0]  groupControlField,
  input wire logic [15:0] operandB,
  input wire logic [15:0] bBusValue,
  input wire logic [15:0] aluResult,
  input wire logic        aluCarryOut,
  input wire logic        effectiveLogicMode,
  input wire logic        effectiveCarryIn,
  input wire logic        gprWriteBlock,
  input wire logic        storedCarryFlag,
  input wire logic        resultZeroFlag,
  input wire logic        resultAllOnesFlag,
  input wire logic        resultSignFlag,
  input wire logic [15:0] processorStatusWord
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic loadCond;
  assign loadCond = (statusUpdateField == 2'h0 || statusUpdateField == 2'h2)
                    && testSelectField == 3'h0 && groupControlField[1];
  // Outputs on the first edge out of reset still hold reset values
  sequence s_go; !$past(rst); endsequence
  sequence s_load; loadCond; endsequence
  sequence s_pick; bSourceClassField == 2'h1 && bSourceSelectField == 4'h3; endsequence
  property p_status_on_b; s_pick |=> bBusValue == $past(processorStatusWord); endproperty
  a_status_on_b: assert property (p_status_on_b) else $error("status word not on b bus");
  property p_other_b; !bSourceClassField[0] |=> bBusValue == $past(operandB); endproperty
  a_other_b: assert property (p_other_b) else $error("b bus not operand b");
  property p_flags;
    s_go |-> resultZeroFlag == (aluResult == 16'h0000) && resultAllOnesFlag == &aluResult
      && resultSignFlag == aluResult[15];
  endproperty
  a_flags: assert property (p_flags) else $error("result flags wrong");
  property p_status_bits;
    s_go |-> processorStatusWord[0] && processorStatusWord[2] == resultZeroFlag
      && processorStatusWord[11:9] == {storedCarryFlag, resultSignFlag, resultAllOnesFlag};
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status word flag bits wrong");
  property p_mode; !bSourceClassField[1] |=> effectiveLogicMode == $past(modeSelectField); endproperty
  a_mode: assert property (p_mode) else $error("mode not from mode field");
  property p_lit;
    bSourceClassField[1] |=> effectiveLogicMode == $past(functionSelectField[1]) && !effectiveCarryIn;
  endproperty
  a_lit: assert property (p_lit) else $error("literal mode or carry wrong");
  property p_gpr; s_go |-> gprWriteBlock == $past(bSourceClassField[1]); endproperty
  a_gpr: assert property (p_gpr) else $error("register write block wrong");
  property p_carry_sel;
    !bSourceClassField[1] && !modeSelectField |=> effectiveCarryIn == ($past(carryInSelectField[1])
      ? ($past(carryInSelectField[0]) | !$past(storedCarryFlag))
      : ($past(carryInSelectField[0]) & $past(storedCarryFlag)));
  endproperty
  a_carry_sel: assert property (p_carry_sel) else $error("carry input select wrong");
  property p_logic_carry; s_go ##0 effectiveLogicMode |-> !aluCarryOut; endproperty
  a_logic_carry: assert property (p_logic_carry) else $error("carry out in logical mode");
  property p_carry_load; s_load |=> storedCarryFlag == aluCarryOut; endproperty
  a_carry_load: assert property (p_carry_load) else $error("stored carry not loaded");
  property p_carry_hold; !loadCond |=> $stable(storedCarryFlag); endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("stored carry changed");
endmodule : alu_function_carry_status_checker

/* File: tb/tb.sv */
// Self-checking bench for the ALU function, carry and status slice
`timescale 1ns/1ps
module tb;
  import alu_function_pkg::*;
  localparam logic [15:0] CARRY_KNOWN = 16'h9ACF;
  localparam int TIMEOUT_CYCLES = 5000;
  logic        sys_clk, rst, pend, eMode, eCin, eCarry, eCo, kCo, eBlk;
  logic        aluCarryOut, effectiveLogicMode, effectiveCarryIn, gprWriteBlock, storedCarryFlag;
  logic        resultZeroFlag, resultAllOnesFlag, resultSignFlag;
  logic [31:0] uword, seed, w, lw;
  logic [15:0] operandA, regValue, literalBits, operandB, ePsw, eRes, eB;
  logic [15:0] bBusValue, aluResult, processorStatusWord;
  int          err_count, total_checks, cyc;

  operand_b_mux partner (.bSourceClassField(uword[1:0]), .regValue(regValue), .literalBits(literalBits),
    .operandB(operandB));
  alu_function_carry_status dut (.sys_clk(sys_clk), .rst(rst), .bSourceClassField(uword[1:0]),
    .bSourceSelectField(uword[5:2]), .functionSelectField(uword[9:6]), .modeSelectField(uword[10]),
    .carryInSelectField(uword[12:11]), .statusUpdateField(uword[14:13]), .testSelectField(uword[17:15]),
    .groupControlField(uword[21:18]), .operandA(operandA), .operandB(operandB), .supervisorFlag(uword[22]),
    .overflowFlag(uword[23]), .shiftCount(uword[31:24]), .keyBits(literalBits[15:12]),
    .bBusValue(bBusValue), .aluResult(aluResult), .aluCarryOut(aluCarryOut),
    .effectiveLogicMode(effectiveLogicMode), .effectiveCarryIn(effectiveCarryIn),
    .gprWriteBlock(gprWriteBlock), .storedCarryFlag(storedCarryFlag), .resultZeroFlag(resultZeroFlag),
    .resultAllOnesFlag(resultAllOnesFlag), .resultSignFlag(resultSignFlag),
    .processorStatusWord(processorStatusWord));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Arithmetic forms as first term plus second term plus carry in
  function automatic logic [16:0] arith(input logic [3:0] f, input logic [15:0] a, b, input logic c);
    logic [15:0] p, q;
    p = (f inside {4'h1, 4'h5, 4'hD}) ? a | b : (f inside {4'h2, 4'hA, 4'hE}) ? a | ~b
      : (f == 4'h3) ? 16'h0000 : (f == 4'h7) ? a & ~b : (f == 4'hB) ? a & b : a;
    q = (f < 4'h3) ? 16'h0000 : (f inside {4'h3, 4'h7, 4'hB, 4'hF}) ? 16'hFFFF
      : (f inside {4'h4, 4'h5}) ? a & ~b : (f == 4'h6) ? ~b : (f inside {4'h8, 4'hA}) ? a & b
      : (f == 4'h9) ? b : a;
    return {1'b0, p} + {1'b0, q} + {16'h0000, c};
  endfunction : arith

  function automatic logic [15:0] logicf(input logic [3:0] f, input logic [15:0] a, b);
    logic [15:0] t [16];
    t = '{~a, ~(a | b), ~a & b, 16'h0000, ~(a & b), ~b, a ^ b, a & ~b,
          ~a | b, ~(a ^ b), b, a & b, 16'hFFFF, a | ~b, a | b, a};
    return t[f];
  endfunction : logicf

  function automatic logic [31:0] mk(input logic [1:0] cls, input logic [3:0] sel, ff, input logic mf,
                                     input logic [1:0] cf, input logic ld);
    return {10'h000, 2'h0, ld, 1'b0, 3'h0, 2'h0, cf, mf, ff, sel, cls};
  endfunction : mk

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step(input logic [31:0] wd, input logic [15:0] a, rv, lit);
    logic [16:0] s;
    @(negedge sys_clk);
    if (pend) begin
      chk("aluResult", aluResult, eRes);
      if (kCo) chk("aluCarryOut", aluCarryOut, {15'h0000, eCo});
      chk("effectiveLogicMode", effectiveLogicMode, {15'h0000, eMode});
      if (!eMode) chk("effectiveCarryIn", effectiveCarryIn, {15'h0000, eCin});
      chk("storedCarryFlag", storedCarryFlag, {15'h0000, eCarry});
      chk("bBusValue", bBusValue, eB);
      chk("gprWriteBlock", gprWriteBlock, {15'h0000, eBlk});
      chk("resultFlags", {13'h0000, resultSignFlag, resultAllOnesFlag, resultZeroFlag},
          {13'h0000, eRes[15], &eRes, eRes == 16'h0000});
      chk("processorStatusWord", processorStatusWord, ePsw);
    end
    eMode = wd[1] ? wd[7] : wd[10];
    eBlk = wd[1];
    kCo = eMode | CARRY_KNOWN[wd[9:6]];
    // Undefined carry results are never loaded, so the model stays in step
    if (!kCo) wd[19] = 1'b0;
    uword = wd;
    operandA = a;
    regValue = rv;
    literalBits = lit;
    #1;
    eCin = wd[1] ? 1'b0 : wd[12] ? (wd[11] | ~eCarry) : (wd[11] & eCarry);
    eB = (wd[5:0] == 6'h0D) ? ePsw : operandB;
    s = arith(wd[9:6], a, eB, eCin);
    eRes = eMode ? logicf(wd[9:6], a, eB) : s[15:0];
    eCo = eMode ? 1'b0 : s[16];
    if ((wd[14:13] == 2'h0 || wd[14:13] == 2'h2) && wd[17:15] == 3'h0 && wd[19]) eCarry = eCo;
    ePsw = {lit[15:12], eCarry, eRes[15], &eRes, wd[23], wd[28:24], eRes == 16'h0000, wd[22], 1'b1};
    pend = 1'b1;
  endtask : step

  task automatic do_reset;
    @(negedge sys_clk);
    rst = 1'b1;
    uword = 32'h0000_0000;
    operandA = 16'h0000;
    literalBits = 16'h0000;
    repeat (3) @(negedge sys_clk);
    chk("statusReset", processorStatusWord, STATUS_RESET);
    chk("carryReset", storedCarryFlag, 16'h0000);
    rst = 1'b0;
    eCarry = 1'b0;
    ePsw = 16'h0005;
    pend = 1'b0;
  endtask : do_reset

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Ceiling well above the roughly 640 cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == TIMEOUT_CYCLES) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    pend = 1'b0;
    regValue = 16'h0000;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    seed = 32'h0001_3338;
    do_reset();
    step(mk(2'h0, 4'h0, 4'h0, 1'b0, 2'h3, 1'b1), 16'hFFFF, 16'h1234, 16'h0000);
    step(mk(2'h0, 4'h0, 4'h9, 1'b0, 2'h1, 1'b0), 16'h0001, 16'h0002, 16'h0000);
    step(mk(2'h0, 4'h0, 4'h9, 1'b0, 2'h2, 1'b0), 16'h0001, 16'h0002, 16'h0000);
    step(mk(2'h0, 4'h0, 4'hF, 1'b0, 2'h0, 1'b1), 16'h0000, 16'h0002, 16'h0000);
    step(mk(2'h0, 4'h0, 4'h6, 1'b0, 2'h3, 1'b1), 16'h0005, 16'h0003, 16'h0000);
    step(mk(2'h0, 4'h0, 4'hC, 1'b0, 2'h0, 1'b1), 16'h8001, 16'h0003, 16'hA000);
    step(mk(2'h0, 4'h0, 4'h3, 1'b0, 2'h3, 1'b1), 16'h0005, 16'h0003, 16'h0000);
    step(mk(2'h0, 4'h0, 4'h1, 1'b0, 2'h0, 1'b1), 16'h0050, 16'h0003, 16'h0000);
    for (int i = 0; i < 16; i++) step(mk(2'h0, 4'h0, i[3:0], 1'b1, 2'h3, 1'b1), 16'h5A0F, 16'h33C3, 16'h0000);
    step(mk(2'h1, 4'h3, 4'h9, 1'b0, 2'h0, 1'b0), 16'h0000, 16'h7777, 16'h0000);
    step(mk(2'h3, 4'h0, 4'h9, 1'b1, 2'h3, 1'b1), 16'hFFFF, 16'h7777, 16'hFFFE);
    step(mk(2'h2, 4'h0, 4'hB, 1'b0, 2'h3, 1'b0), 16'hFFFF, 16'h7777, 16'h00FF);
    for (int i = 0; i < 600; i++) begin
      if (i == 300) do_reset();
      seed = xs(seed);
      w = seed;
      seed = xs(seed);
      if (seed[0]) w[17:15] = 3'h0;
      // A select on a call result is refused by strict front ends
      lw = xs(w);
      step(w, seed[31:16], seed[15:0], lw[15:0]);
    end
    step(32'h0000_0000, 16'h0000, 16'h0000, 16'h0000);
    final_report();
  end
endmodule : tb

bind alu_function_carry_status alu_function_carry_status_checker chk_i (.sys_clk(sys_clk), .rst(rst),
  .bSourceClassField(bSourceClassField), .bSourceSelectField(bSourceSelectField),
  .functionSelectField(functionSelectField), .modeSelectField(modeSelectField),
  .carryInSelectField(carryInSelectField), .statusUpdateField(statusUpdateField),
  .testSelectField(testSelectField), .groupControlField(groupControlField), .operandB(operandB),
  .bBusValue(bBusValue), .aluResult(aluResult), .aluCarryOut(aluCarryOut),
  .effectiveLogicMode(effectiveLogicMode), .effectiveCarryIn(effectiveCarryIn), .gprWriteBlock(gprWriteBlock),
  .storedCarryFlag(storedCarryFlag), .resultZeroFlag(resultZeroFlag), .resultAllOnesFlag(resultAllOnesFlag),
  .resultSignFlag(resultSignFlag), .processorStatusWord(processorStatusWord));
